/* design/dtm_pkg.sv */
// constants for the memory-mapped data cache tag view
package dtm_pkg;
	// ************************************************************
	// geometry
	// ************************************************************
	localparam int SET_BITS = 4;
	localparam int SETS = 16;
	localparam int WAY_BITS = 2;
	localparam int WAYS = 4;
	localparam int LINE_BITS = WAY_BITS + SET_BITS;
	localparam int LINES = WAYS * SETS;
	localparam int TAG_BITS = 27 - SET_BITS;
	localparam int DIRTY_BITS = 8;
	localparam int REPL_BITS = 6;

	// ************************************************************
	// mapped address fields
	// ************************************************************
	localparam int BYTE_LSB = 0;
	localparam int BYTE_BITS = 5;
	localparam int SET_LSB = BYTE_LSB + BYTE_BITS;
	localparam int WAY_LSB = SET_LSB + SET_BITS;
	localparam int TD_POS = WAY_LSB + WAY_BITS;
	localparam int BASE_LSB = TD_POS + 1;
	localparam int BASE_BITS = 32 - BASE_LSB;
	localparam int WSEL_LSB = 2;
	localparam logic [BASE_BITS-1:0] BASE_ADDR = 20'hF_0000;

	// ************************************************************
	// tag word layout
	// ************************************************************
	localparam logic [1:0] WORD_ADDR = 2'h0;
	localparam logic [1:0] WORD_DIRTY = 2'h1;
	localparam logic [1:0] WORD_EMPTY = 2'h2;
	localparam logic [1:0] WORD_REPL = 2'h3;
	localparam int VALID_POS = 0;
	localparam int LOCK_POS = 1;
	localparam int TAG_LSB = 32 - TAG_BITS;
	localparam int MRU_LSB = 4;
	localparam int SEC_LSB = 2;
	localparam int THIRD_LSB = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [REPL_BITS-1:0] REPL_RESET = 6'h24;
	localparam logic [TAG_BITS-1:0] TAG_RESET = 23'h00_0000;
	localparam logic [DIRTY_BITS-1:0] DIRTY_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : dtm_pkg

/* design/dtm_tag_map.sv */
// data cache tag arrays with their memory-mapped word view
`timescale 1ns/1ps
// Function
// RQ1: word 0 bit 0 is valid flag
// RQ2: word 0 bit 1 is lock flag
// RQ3: tag fills upper 27 minus log2(sets) bits
// RQ4: undefined bits read zero, writes ignored
// RQ5: word 1 low 8 bits dirty flags
// RQ6: dirty bit 0 belongs to word 0
// RQ7: word 2 reads zero, writes dropped
// RQ8: word 3 low 6 bits shared set replacement
// RQ9: bits 5:4, 3:2, 1:0 most to third recent
// RQ10: replace the way absent from all fields
// RQ11: software never repeats a way in fields
// RQ12: word index modulo four picks tag word
// RQ13: select bit set means tags, clear data
// RQ14: 2-bit way field picks line in set
// RQ15: 5-bit byte field picks byte in line
// RQ16: accessor uses aligned 32-bit accesses only
// RQ17: hit or fill makes way most recent; a mapped word 3 write to the same set in the same cycle wins instead
// RQ18: writes to words 0,1,3 read back
module dtm_tag_map (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// mapped access port
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [31:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	output logic acc_ack_reg,
	output logic [31:0] acc_rdata_reg,
	output logic dmem_route_reg,
	// cache use port: hit or fill of a way
	input wire logic use_valid,
	input wire logic [dtm_pkg::SET_BITS-1:0] use_set,
	input wire logic [dtm_pkg::WAY_BITS-1:0] use_way,
	// replacement query
	input wire logic repl_req,
	input wire logic [dtm_pkg::SET_BITS-1:0] repl_set,
	output logic repl_ack_reg,
	output logic [dtm_pkg::WAY_BITS-1:0] repl_way_reg
);
	// ************************************************************
	// address decode
	// ************************************************************
	logic mapped;
	logic tag_sel;
	logic data_sel;
	logic tag_wr;
	logic tag_rd;
	logic [1:0] wsel;
	logic [dtm_pkg::LINE_BITS-1:0] a_line;
	logic [dtm_pkg::SET_BITS-1:0] a_set;
	logic [31:0] rd_next;
	logic [dtm_pkg::REPL_BITS-1:0] repl_view;

	// base match, then tag/data split
	assign mapped = acc_valid && (acc_addr[31:dtm_pkg::BASE_LSB] == dtm_pkg::BASE_ADDR);
	assign tag_sel = mapped && acc_addr[dtm_pkg::TD_POS]; // see RQ13
	assign data_sel = mapped && !acc_addr[dtm_pkg::TD_POS]; // see RQ13
	assign tag_wr = tag_sel && acc_write;
	assign tag_rd = tag_sel && !acc_write;
	// byte bits 4:2 give the word; only its low two bits matter
	assign wsel = acc_addr[dtm_pkg::WSEL_LSB +: 2]; // see RQ12 see RQ15
	// way field above set field gives the line number
	assign a_line = acc_addr[dtm_pkg::SET_LSB +: dtm_pkg::LINE_BITS]; // see RQ14
	assign a_set = acc_addr[dtm_pkg::SET_LSB +: dtm_pkg::SET_BITS];

	// ************************************************************
	// storage
	// ************************************************************
	logic valid_reg [dtm_pkg::LINES];
	logic lock_reg [dtm_pkg::LINES];
	logic [dtm_pkg::TAG_BITS-1:0] tag_reg [dtm_pkg::LINES];
	logic [dtm_pkg::DIRTY_BITS-1:0] dirty_reg [dtm_pkg::LINES];
	logic [dtm_pkg::REPL_BITS-1:0] lru_reg [dtm_pkg::SETS];

	// promote a way to most recent, shifting older entries down
	function automatic logic [5:0] dtm_promote(input logic [5:0] r, input logic [1:0] w);
		logic [5:0] res;
		res = r;
		if (w == r[dtm_pkg::MRU_LSB +: 2])
			res = r;
		else if (w == r[dtm_pkg::SEC_LSB +: 2])
			res = {w, r[dtm_pkg::MRU_LSB +: 2], r[dtm_pkg::THIRD_LSB +: 2]};
		else
			res = {w, r[dtm_pkg::MRU_LSB +: 2], r[dtm_pkg::SEC_LSB +: 2]};
		return res;
	endfunction : dtm_promote

	// pick the way named in none of the three recency fields
	function automatic logic [1:0] dtm_victim(input logic [5:0] r);
		logic [3:0] seen;
		logic [1:0] v;
		seen = 4'h0;
		v = 2'h0;
		seen[r[dtm_pkg::MRU_LSB +: 2]] = 1'b1;
		seen[r[dtm_pkg::SEC_LSB +: 2]] = 1'b1;
		seen[r[dtm_pkg::THIRD_LSB +: 2]] = 1'b1;
		for (int w = dtm_pkg::WAYS - 1; w >= 0; w--)
		begin
			if (!seen[w])
				v = 2'(w);
		end
		return v;
	endfunction : dtm_victim

	// per-line address word and dirty word
	genvar g;
	generate
		for (g = 0; g < dtm_pkg::LINES; g++)
		begin : g_line
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					valid_reg[g] <= 1'b0;
					lock_reg[g] <= 1'b0;
					tag_reg[g] <= dtm_pkg::TAG_RESET;
				end
				else if (tag_wr && wsel == dtm_pkg::WORD_ADDR && a_line == g)
				begin
					valid_reg[g] <= acc_wdata[dtm_pkg::VALID_POS]; // see RQ1 see RQ18
					lock_reg[g] <= acc_wdata[dtm_pkg::LOCK_POS]; // see RQ2 see RQ18
					tag_reg[g] <= acc_wdata[31:dtm_pkg::TAG_LSB]; // see RQ3 see RQ18
				end
			end

			// dirty flags, bit n for data word n
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					dirty_reg[g] <= dtm_pkg::DIRTY_RESET;
				else if (tag_wr && wsel == dtm_pkg::WORD_DIRTY && a_line == g)
					dirty_reg[g] <= acc_wdata[dtm_pkg::DIRTY_BITS-1:0]; // see RQ5 see RQ6
			end
		end

		// one shared replacement word per set; mapped write beats use
		for (g = 0; g < dtm_pkg::SETS; g++)
		begin : g_set
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					lru_reg[g] <= dtm_pkg::REPL_RESET;
				else if (tag_wr && wsel == dtm_pkg::WORD_REPL && a_set == g)
					lru_reg[g] <= acc_wdata[dtm_pkg::REPL_BITS-1:0]; // see RQ8 see RQ18
				else if (use_valid && use_set == g)
					lru_reg[g] <= dtm_promote(lru_reg[g], use_way); // see RQ17 see RQ9
			end
		end
	endgenerate

	// ************************************************************
	// read path
	// ************************************************************
	// read mux, undefined bits and word 2 give zero
	always_comb
	begin
		rd_next = dtm_pkg::WORD_ZERO;
		case (wsel)
			dtm_pkg::WORD_ADDR:
			begin
				rd_next[31:dtm_pkg::TAG_LSB] = tag_reg[a_line]; // see RQ3
				rd_next[dtm_pkg::LOCK_POS] = lock_reg[a_line]; // see RQ2
				rd_next[dtm_pkg::VALID_POS] = valid_reg[a_line]; // see RQ1 see RQ4
			end
			dtm_pkg::WORD_DIRTY:
				rd_next[dtm_pkg::DIRTY_BITS-1:0] = dirty_reg[a_line]; // see RQ5 see RQ4
			dtm_pkg::WORD_REPL:
				rd_next[dtm_pkg::REPL_BITS-1:0] = lru_reg[a_set]; // see RQ8 see RQ4
			default:
				rd_next = dtm_pkg::WORD_ZERO; // see RQ7
		endcase
	end

	// answer one cycle after a tag access, data hits routed away
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_ack_reg <= 1'b0;
			acc_rdata_reg <= dtm_pkg::WORD_ZERO;
			dmem_route_reg <= 1'b0;
		end
		else
		begin
			acc_ack_reg <= tag_sel;
			dmem_route_reg <= data_sel; // see RQ13
			if (tag_rd)
				acc_rdata_reg <= rd_next;
		end
	end

	// ************************************************************
	// replacement choice
	// ************************************************************
	assign repl_view = lru_reg[repl_set];

	// victim way one cycle after the query
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			repl_ack_reg <= 1'b0;
			repl_way_reg <= 2'h0;
		end
		else
		begin
			repl_ack_reg <= repl_req;
			if (repl_req)
				repl_way_reg <= dtm_victim(repl_view); // see RQ10
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	logic rd_done_reg;
	logic [1:0] rd_wsel_reg;

	// remembers the previous cycle's word select and whether that cycle was a mapped tag read
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_done_reg <= 1'b0;
			rd_wsel_reg <= 2'h0;
		end
		else
		begin
			rd_done_reg <= tag_rd;
			rd_wsel_reg <= wsel;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_then_rd(logic [1:0] w);
		(tag_wr && wsel == w) ##1 (tag_rd && acc_addr == $past(acc_addr));
	endsequence

	a_valid_readback: assert property (s_wr_then_rd(2'h0) |=> // see RQ1
		acc_rdata_reg[0] == $past(acc_wdata[0], 2))
		else $error("valid flag not read back");
	a_lock_readback: assert property (s_wr_then_rd(2'h0) |=> // see RQ2
		acc_rdata_reg[1] == $past(acc_wdata[1], 2))
		else $error("lock flag not read back");
	a_tag_readback: assert property (s_wr_then_rd(2'h0) |=> // see RQ3
		acc_rdata_reg[31:9] == $past(acc_wdata[31:9], 2) && acc_rdata_reg[8:2] == 7'h00)
		else $error("address tag not read back");
	a_dirty_readback: assert property (s_wr_then_rd(2'h1) |=> // see RQ6
		acc_rdata_reg == {24'h00_0000, $past(acc_wdata[7:0], 2)})
		else $error("dirty flags not read back");
	a_empty_word: assert property (rd_done_reg && rd_wsel_reg == 2'h2 |-> // see RQ7
		acc_rdata_reg == 32'h0000_0000)
		else $error("empty word not zero");
	a_high_zero: assert property (rd_done_reg && rd_wsel_reg != 2'h0 |-> // see RQ4
		acc_rdata_reg[31:8] == 24'h00_0000)
		else $error("undefined bits not zero");
	a_mru_update: assert property (use_valid && !(tag_wr && wsel == 2'h3) |=> // see RQ17
		lru_reg[$past(use_set)][5:4] == $past(use_way))
		else $error("used way not most recent");
	a_victim_free: assert property (repl_req |=> repl_ack_reg && // see RQ10
		repl_way_reg != $past(repl_view[5:4]) && repl_way_reg != $past(repl_view[3:2]) &&
		repl_way_reg != $past(repl_view[1:0]))
		else $error("victim listed as recent");
	a_data_route: assert property (data_sel |=> dmem_route_reg && !acc_ack_reg) // see RQ13
		else $error("data access not routed");

	c_tag_read: cover property (s_wr_then_rd(2'h0));
	c_repl_write: cover property (tag_wr && wsel == 2'h3 ##1 repl_req);
	c_use_promote: cover property (use_valid ##1 use_valid && use_set == $past(use_set));
endmodule : dtm_tag_map

/* bench/dtm_lsu_model.sv */
// load/store side model issuing mapped tag accesses
`timescale 1ns/1ps
module dtm_lsu_model (
	// clock
	input wire logic core_clk,
	// mapped access requests
	output logic acc_valid,
	output logic acc_write,
	output logic [31:0] acc_addr,
	output logic [31:0] acc_wdata,
	// answers from the tag view
	input wire logic acc_ack_reg,
	input wire logic [31:0] acc_rdata_reg,
	input wire logic dmem_route_reg
);
	// idle request lines at time zero
	initial
	begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_addr = 32'h0000_0000;
		acc_wdata = 32'h0000_0000;
	end

	// one request cycle, answer sampled while its pulse stands, lines then released inverted
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic ack, output logic rt, output logic [31:0] rd);
		@(negedge core_clk);
		acc_valid = 1'b1;
		acc_write = wr;
		acc_addr = {a[31:2], 2'b00};
		acc_wdata = d;
		@(negedge core_clk);
		ack = acc_ack_reg;
		rt = dmem_route_reg;
		rd = acc_rdata_reg;
		acc_valid = 1'b0;
		acc_addr = ~acc_addr;
		acc_wdata = ~acc_wdata;
	endtask : xfer

	// write then read of the same word in back to back cycles
	task automatic xfer_wr_rd(input logic [31:0] a, input logic [31:0] d,
		output logic ack, output logic [31:0] rd);
		@(negedge core_clk);
		acc_valid = 1'b1;
		acc_write = 1'b1;
		acc_addr = {a[31:2], 2'b00};
		acc_wdata = d;
		@(negedge core_clk);
		ack = acc_ack_reg;
		acc_write = 1'b0;
		acc_wdata = ~acc_wdata;
		@(negedge core_clk);
		ack = ack & acc_ack_reg;
		rd = acc_rdata_reg;
		acc_valid = 1'b0;
		acc_addr = ~acc_addr;
	endtask : xfer_wr_rd
endmodule : dtm_lsu_model

/* bench/dtm_tag_map_tb_top.sv */
// self-checking bench for the mapped tag view
`timescale 1ns/1ps
module dtm_tag_map_tb_top;
	// ************************************************************
	// signals and reference state
	// ************************************************************
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic acc_valid, acc_write, acc_ack_reg, dmem_route_reg;
	logic [31:0] acc_addr, acc_wdata, acc_rdata_reg;
	logic use_valid = 1'b0;
	logic [3:0] use_set = 4'h0;
	logic [1:0] use_way = 2'h0;
	logic repl_req = 1'b0;
	logic [3:0] repl_set = 4'h0;
	logic repl_ack_reg;
	logic [1:0] repl_way_reg;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] w0 [64];
	logic [31:0] w1 [64];
	logic [5:0] rp [16];

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// ************************************************************
	// design and requester
	// ************************************************************
	dtm_tag_map dut (.core_clk(core_clk), .rst_n(rst_n), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_ack_reg(acc_ack_reg), .acc_rdata_reg(acc_rdata_reg),
		.dmem_route_reg(dmem_route_reg), .use_valid(use_valid), .use_set(use_set),
		.use_way(use_way), .repl_req(repl_req), .repl_set(repl_set),
		.repl_ack_reg(repl_ack_reg), .repl_way_reg(repl_way_reg));
	dtm_lsu_model lsu (.core_clk(core_clk), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack_reg(acc_ack_reg),
		.acc_rdata_reg(acc_rdata_reg), .dmem_route_reg(dmem_route_reg));

	// ************************************************************
	// helpers
	// ************************************************************
	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// new recency list: used way first, others shifted down
	function automatic logic [5:0] upd(input logic [5:0] r, input logic [1:0] w);
		if (w == r[5:4])
			return r;
		if (w == r[3:2])
			return {w, r[5:4], r[1:0]};
		return {w, r[5:4], r[3:2]};
	endfunction : upd

	// reference value of one tag word
	function automatic logic [31:0] ref_word(input logic [1:0] wy, input logic [3:0] st,
		input logic [2:0] wi);
		logic [31:0] e;
		case (wi[1:0])
			2'h0: e = w0[{wy, st}];
			2'h1: e = w1[{wy, st}];
			2'h3: e = {26'h0, rp[st]};
			default: e = 32'h0000_0000;
		endcase
		return e;
	endfunction : ref_word

	// reference update for a write of one tag word
	task automatic note_write(input logic [1:0] wy, input logic [3:0] st,
		input logic [2:0] wi, input logic [31:0] d);
		if (wi[1:0] == 2'h0)
			w0[{wy, st}] = d & 32'hFFFF_FE03;
		else if (wi[1:0] == 2'h1)
			w1[{wy, st}] = d & 32'h0000_00FF;
		else if (wi[1:0] == 2'h3)
			rp[st] = d[5:0];
	endtask : note_write

	// one tag word access compared with the reference
	task automatic acc(input logic wr, input logic [1:0] wy, input logic [3:0] st,
		input logic [2:0] wi, input logic [31:0] d);
		logic ack;
		logic rt;
		logic [31:0] rd;
		lsu.xfer(wr, {20'hF_0000, 1'b1, wy, st, wi, 2'b00}, d, ack, rt, rd);
		check("ack", {31'h0, ack}, 32'h0000_0001);
		check("route", {31'h0, rt}, 32'h0000_0000);
		if (!wr)
			check("rdata", rd, ref_word(wy, st, wi));
		else
			note_write(wy, st, wi, d);
	endtask : acc

	// write and read back of one tag word in consecutive cycles
	task automatic acc_wr_rd(input logic [1:0] wy, input logic [3:0] st,
		input logic [2:0] wi, input logic [31:0] d);
		logic ack;
		logic [31:0] rd;
		lsu.xfer_wr_rd({20'hF_0000, 1'b1, wy, st, wi, 2'b00}, d, ack, rd);
		note_write(wy, st, wi, d);
		check("b2b_ack", {31'h0, ack}, 32'h0000_0001);
		check("b2b_rdata", rd, ref_word(wy, st, wi));
	endtask : acc_wr_rd

	task automatic use_line(input logic [3:0] st, input logic [1:0] wy);
		@(negedge core_clk);
		use_valid = 1'b1;
		use_set = st;
		use_way = wy;
		@(negedge core_clk);
		use_valid = 1'b0;
		rp[st] = upd(rp[st], wy);
	endtask : use_line

	task automatic query(input logic [3:0] st);
		logic [1:0] v;
		v = 2'h0;
		for (int k = 3; k >= 0; k--)
			if (rp[st][5:4] != 2'(k) && rp[st][3:2] != 2'(k) && rp[st][1:0] != 2'(k))
				v = 2'(k);
		@(negedge core_clk);
		repl_req = 1'b1;
		repl_set = st;
		@(negedge core_clk);
		check("repl_ack", {31'h0, repl_ack_reg}, 32'h0000_0001);
		check("victim", {30'h0, repl_way_reg}, {30'h0, v});
		repl_req = 1'b0;
	endtask : query

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [31:0] r;
		logic [31:0] d;
		logic [1:0] a;
		logic [1:0] b;
		logic ack;
		logic rt;
		logic [31:0] rd;
		void'($urandom(33));
		for (int i = 0; i < 64; i++)
		begin
			w0[i] = 32'h0000_0000;
			w1[i] = 32'h0000_0000;
			rp[i[3:0]] = 6'h24;
		end
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		acc(1'b0, 2'h1, 4'h5, 3'h7, 32'h0000_0000);
		query(4'h5);
		// random accesses, uses and queries
		for (int i = 0; i < 400; i++)
		begin
			r = $urandom;
			d = $urandom;
			a = r[15:14];
			b = a + 2'h1 + {1'b0, r[13]};
			d[5:0] = {a, b, b + 2'h1}; // distinct ways
			if (r[11:9] < 3'h4)
				acc(r[12], r[1:0], r[5:2], r[8:6], d);
			else if (r[11:9] == 3'h4)
				acc_wr_rd(r[1:0], r[5:2], r[8:6], d);
			else if (r[11:9] < 3'h7)
				use_line(r[5:2], r[1:0]);
			else
				query(r[5:2]);
		end
		// data half and foreign base
		lsu.xfer(1'b0, 32'hF000_0204, 32'h0000_0000, ack, rt, rd);
		check("data_ack", {31'h0, ack}, 32'h0000_0000);
		check("data_route", {31'h0, rt}, 32'h0000_0001);
		lsu.xfer(1'b1, 32'hE000_0800, 32'hFFFF_FFFF, ack, rt, rd);
		check("foreign", {30'h0, ack, rt}, 32'h0000_0000);
		acc(1'b0, 2'h0, 4'h0, 3'h0, 32'h0000_0000);
		complete_run();
	end
endmodule : dtm_tag_map_tb_top
